// *** common/cma_pkg.sv ***
// Contract
// - two modes: 64-kbyte narrow, 16-Mbyte wide
// - narrow mode unavailable; pins only select wide
// - narrow mode keeps low 16 address bits
// - narrow inc/dec carry reaches upper half
// - narrow vectors from zero, 16-bit entries
// - narrow memory-indirect fetches one 16-bit word
// - wide vectors 32 bits, low 24 used
// - wide memory-indirect longword, top byte zero
// - push pc; exception adds ccr, valid exr
// - multiply extend takes 3/4/4/5 states
// - add/sub 1 state, divides 12/20
// - wide mode upper halves usable as address
// - sleep enters power-down state
// - 24-bit pc, fetch lsb forced zero
package cma_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int CMA_ADDR_W = 24;
    localparam int CMA_NARROW_W = 16;
    localparam int CMA_WORD_W = 16;
    // ****************************************
    // layouts and reset values
    // ****************************************
    localparam logic [1:0] CMA_WIDE_VEC_SHIFT = 2'h2;
    localparam logic [1:0] CMA_NARROW_VEC_SHIFT = 2'h1;
    localparam logic [23:0] CMA_WORD_BYTES = 24'h000002;
    localparam logic [23:0] CMA_PC_RESET = 24'h000000;
    localparam logic [31:0] CMA_SP_RESET = 32'h00000000;
    localparam logic CMA_NARROW_OFFERED = 1'b0;
    // ****************************************
    // execution state counts
    // ****************************************
    localparam logic [4:0] CMA_ST_ADDSUB = 5'h01;
    localparam logic [4:0] CMA_ST_MULU_B = 5'h03;
    localparam logic [4:0] CMA_ST_MULU_W = 5'h04;
    localparam logic [4:0] CMA_ST_MULS_B = 5'h04;
    localparam logic [4:0] CMA_ST_MULS_W = 5'h05;
    localparam logic [4:0] CMA_ST_DIV_B = 5'h0c;
    localparam logic [4:0] CMA_ST_DIV_W = 5'h14;
    // ****************************************
    // operations
    // ****************************************
    typedef enum logic [2:0]
    {
        cma_op_jump, cma_op_call, cma_op_exception, cma_op_exec, cma_op_sleep
    } cma_op_t;
    typedef enum logic [2:0]
    {
        cma_alu_addsub, cma_alu_mulu_b, cma_alu_mulu_w, cma_alu_muls_b,
        cma_alu_muls_w, cma_alu_div_b, cma_alu_div_w
    } cma_alu_t;
endpackage

// *** rtl/cma_core.sv ***
`timescale 1ns/10ps
module cma_core
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // mode pin, asynchronous
    input wire logic mode_pin,
    output logic mode_wide,
    // operation request
    input wire logic op_valid,
    input cma_pkg::cma_op_t op_kind,
    input wire logic [7:0] op_arg,
    output logic op_ready,
    output logic op_done,
    // cpu state used by the sequences
    input wire logic [31:0] sp_in,
    input wire logic [7:0] ccr_in,
    input wire logic [7:0] exr_in,
    input wire logic exr_valid,
    output logic [31:0] sp_out,
    output logic [23:0] program_counter,
    input wire logic pc_advance,
    output logic [23:0] fetch_addr,
    // pre-decrement / post-increment address update
    input wire logic idx_go,
    input wire logic idx_post,
    input wire logic [2:0] idx_step,
    input wire logic [31:0] idx_reg_in,
    output logic [31:0] idx_reg_out,
    output logic [23:0] effective_addr,
    // memory system
    output logic mem_req,
    output logic mem_we,
    output logic [23:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // power-down
    input wire logic wake,
    output logic power_down
);
    import cma_pkg::*;

    typedef enum logic [2:0] {cma_idle, cma_push, cma_fetch, cma_exec, cma_sleep} cma_state_t;

    // ****************************************
    // mode capture
    // ****************************************
    logic mode_meta;
    logic mode_sync;
    logic mode_held;
    always_ff @(posedge clk)
    begin
        mode_meta <= mode_pin;
        mode_sync <= mode_meta;
    end
    // sampled each clock while in reset, frozen after release
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            mode_held <= mode_sync | ~CMA_NARROW_OFFERED;
    end
    always_comb
    begin
        mode_wide = mode_held;
    end

    // ****************************************
    // address masking
    // ****************************************
    function automatic logic [23:0] cma_mask(input logic [23:0] a, input logic wide);
        if (wide)
            cma_mask = a;
        else
            cma_mask = {8'h00, a[CMA_NARROW_W-1:0]};
    endfunction

    // ****************************************
    // sequencer
    // ****************************************
    cma_state_t state;
    logic [15:0] push_word [0:2];
    logic [1:0] push_cnt;
    logic [1:0] push_idx;
    logic [23:0] fetch_base;
    logic fetch_second;
    logic [15:0] fetch_hi;
    logic [4:0] exec_left;
    logic [23:0] next_push_addr;
    logic [23:0] next_fetch_addr;
    logic [4:0] next_states;

    always_comb
    begin
        next_push_addr = sp_out[23:0] - CMA_WORD_BYTES;
        next_fetch_addr = fetch_second ? fetch_base + CMA_WORD_BYTES : fetch_base;
        unique case (cma_alu_t'(op_arg[2:0]))
            cma_alu_addsub: next_states = CMA_ST_ADDSUB;
            cma_alu_mulu_b: next_states = CMA_ST_MULU_B;
            cma_alu_mulu_w: next_states = CMA_ST_MULU_W;
            cma_alu_muls_b: next_states = CMA_ST_MULS_B;
            cma_alu_muls_w: next_states = CMA_ST_MULS_W;
            cma_alu_div_b: next_states = CMA_ST_DIV_B;
            cma_alu_div_w: next_states = CMA_ST_DIV_W;
            default: next_states = CMA_ST_ADDSUB;
        endcase
    end

    assign op_ready = (state == cma_idle);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= cma_idle;
            push_cnt <= 2'h0;
            push_idx <= 2'h0;
            fetch_base <= 24'h000000;
            fetch_second <= 1'b0;
            exec_left <= 5'h00;
            push_word[0] <= 16'h0000;
            push_word[1] <= 16'h0000;
            push_word[2] <= 16'h0000;
        end
        else
        begin
            unique case (state)
                cma_idle:
                    if (op_valid)
                    begin
                        push_idx <= 2'h0;
                        fetch_second <= 1'b0;
                        // vector table from zero, entry size by mode
                        if (op_kind == cma_op_exception)
                            fetch_base <= mode_wide ? {14'h0000, op_arg, 2'h0}
                                                    : {15'h0000, op_arg, 1'h0};
                        else
                            fetch_base <= {16'h0000, op_arg};
                        // stack image: lowest address pushed last
                        push_word[0] <= program_counter[15:0];
                        push_word[1] <= mode_wide ? {ccr_in, program_counter[23:16]}
                                                  : {ccr_in, 8'h00};
                        push_word[2] <= {exr_in, 8'h00};
                        unique case (op_kind)
                            cma_op_jump: state <= cma_fetch;
                            cma_op_call:
                            begin
                                // narrow return address is one word
                                push_word[1] <= {8'h00, program_counter[23:16]};
                                push_cnt <= mode_wide ? 2'h2 : 2'h1;
                                state <= cma_push;
                            end
                            cma_op_exception:
                            begin
                                push_cnt <= exr_valid ? 2'h3 : 2'h2;
                                state <= cma_push;
                            end
                            cma_op_exec:
                            begin
                                exec_left <= next_states;
                                state <= cma_exec;
                            end
                            cma_op_sleep: state <= cma_sleep;
                            default: state <= cma_idle;
                        endcase
                    end
                cma_push:
                    if (mem_ack)
                    begin
                        push_idx <= push_idx + 2'h1;
                        if (push_idx + 2'h1 == push_cnt)
                            state <= cma_fetch;
                    end
                cma_fetch:
                    if (mem_ack)
                    begin
                        if (mode_wide && !fetch_second)
                            fetch_second <= 1'b1;
                        else
                            state <= cma_idle;
                    end
                cma_exec:
                    if (exec_left == 5'h01)
                        state <= cma_idle;
                    else
                        exec_left <= exec_left - 5'h01;
                cma_sleep:
                    if (wake)
                        state <= cma_idle;
                default: state <= cma_idle;
            endcase
        end
    end

    // ****************************************
    // stack pointer
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            sp_out <= CMA_SP_RESET;
        else if (state == cma_idle && op_valid)
            sp_out <= sp_in;
        else if (state == cma_push && mem_ack)
            sp_out <= {sp_out[31:24], next_push_addr};
    end

    // ****************************************
    // memory requests
    // ****************************************
    always_comb
    begin
        mem_req = (state == cma_push) || (state == cma_fetch);
        mem_we = (state == cma_push);
        mem_wdata = (state == cma_push) ? push_word[push_idx] : 16'h0000;
        if (state == cma_push)
            mem_addr = cma_mask(next_push_addr, mode_wide);
        else
            mem_addr = cma_mask(next_fetch_addr, mode_wide);
    end

    // ****************************************
    // program counter
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            program_counter <= CMA_PC_RESET;
            fetch_hi <= 16'h0000;
        end
        else if (state == cma_fetch && mem_ack)
        begin
            if (mode_wide && !fetch_second)
                fetch_hi <= mem_rdata;
            else if (mode_wide)
                program_counter <= {fetch_hi[7:0], mem_rdata};
            else
                program_counter <= {8'h00, mem_rdata};
        end
        else if (pc_advance && state == cma_idle)
            program_counter <= cma_mask(program_counter + CMA_WORD_BYTES, mode_wide);
    end
    assign fetch_addr = {program_counter[23:1], 1'b0};

    // ****************************************
    // completion and power-down
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            op_done <= 1'b0;
        else
            op_done <= (state == cma_fetch && mem_ack && (fetch_second || !mode_wide))
                    || (state == cma_exec && exec_left == 5'h01)
                    || (state == cma_sleep && wake);
    end
    assign power_down = (state == cma_sleep);

    // ****************************************
    // pre-decrement / post-increment
    // ****************************************
    logic [31:0] idx_sum;
    always_comb
    begin
        if (idx_post)
            idx_sum = idx_reg_in + {29'h0, idx_step};
        else
            idx_sum = idx_reg_in - {29'h0, idx_step};
    end
    // full 32-bit sum: low-half carry spills into the upper half in both modes
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            idx_reg_out <= 32'h00000000;
            effective_addr <= 24'h000000;
        end
        else if (idx_go)
        begin
            idx_reg_out <= idx_sum;
            effective_addr <= cma_mask(idx_post ? idx_reg_in[23:0] : idx_sum[23:0],
                                       mode_wide);
        end
    end
endmodule

// *** tb/cma_mem_model.sv ***
`timescale 1ns/10ps
module cma_mem_model
(
    // clock
    input wire logic clk,
    // word bus from the core
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack,
    // wait states per word
    input wire logic [1:0] lat
);
    logic [15:0] m [0:255];
    logic [15:0] last = 16'h0;
    logic [1:0] cnt = 2'h0;
    assign mem_ack = mem_req && cnt >= lat;
    // idle bus shows inverted data so a stale word never matches
    assign mem_rdata = mem_ack ? m[mem_addr[8:1]] : ~last;
    // plain always: the bench preloads m directly
    always @(posedge clk)
    begin
        cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
        if (mem_ack)
        begin
            last <= mem_rdata;
            if (mem_we)
                m[mem_addr[8:1]] <= mem_wdata;
        end
    end
endmodule

// *** tb/cma_core_properties.sv ***
`timescale 1ns/10ps
module cma_core_properties
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // watched ports
    input wire logic mode_wide,
    input wire logic op_valid,
    input cma_pkg::cma_op_t op_kind,
    input wire logic [7:0] op_arg,
    input wire logic op_ready,
    input wire logic op_done,
    input wire logic [23:0] program_counter,
    input wire logic [23:0] fetch_addr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [23:0] mem_addr,
    input wire logic mem_ack,
    input wire logic wake,
    input wire logic power_down
);
    import cma_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic take;
    logic ex;
    assign take = op_valid && op_ready;
    assign ex = take && op_kind == cma_op_exec;
    a_mode_wide_only: assert property (mode_wide)
        else $error("mode not wide");
    a_fetch_lsb_zero: assert property (fetch_addr == {program_counter[23:1], 1'b0})
        else $error("fetch lsb set");
    a_addsub_one: assert property (ex && op_arg[2:0] == cma_alu_addsub |=> !op_done ##1 op_done)
        else $error("add time");
    a_mulu_b_three: assert property (ex && op_arg[2:0] == cma_alu_mulu_b
        |=> !op_done [*3] ##1 op_done)
        else $error("mulu byte time");
    a_muls_w_five: assert property (ex && op_arg[2:0] == cma_alu_muls_w
        |=> !op_done [*5] ##1 op_done)
        else $error("muls word time");
    a_div_b_twelve: assert property (ex && op_arg[2:0] == cma_alu_div_b |-> ##13 op_done)
        else $error("div byte time");
    a_div_w_twenty: assert property (ex && op_arg[2:0] == cma_alu_div_w |-> ##21 op_done)
        else $error("div word time");
    a_req_held: assert property (mem_req && !mem_ack
        |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("request dropped");
    a_sleep_enter: assert property (take && op_kind == cma_op_sleep |-> ##[1:2] power_down)
        else $error("no power down");
    a_sleep_hold: assert property (power_down && !wake |=> power_down)
        else $error("power down left");
    c_exception: cover property (take && op_kind == cma_op_exception);
    c_wake: cover property (power_down ##1 wake);
    c_wait: cover property (mem_req && !mem_ack);
endmodule
bind cma_core cma_core_properties u_props (.clk, .rst_b, .mode_wide, .op_valid, .op_kind,
    .op_arg, .op_ready, .op_done, .program_counter, .fetch_addr, .mem_req, .mem_we,
    .mem_addr, .mem_ack, .wake, .power_down);

// *** tb/cma_core_test.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cma_core_test;
    import cma_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, mode_pin = 1'b1, op_valid = 1'b0, exr_valid = 1'b0;
    logic pc_advance = 1'b0, idx_go = 1'b0, idx_post = 1'b0, wake = 1'b0;
    cma_op_t op_kind = cma_op_exec;
    logic [7:0] op_arg = 8'h0, ccr_in = 8'h0, exr_in = 8'h0;
    logic [31:0] sp_in = 32'h0, idx_reg_in = 32'h0, sp_out, idx_reg_out;
    logic [2:0] idx_step = 3'h0;
    logic [1:0] lat = 2'h0;
    logic mode_wide, op_ready, op_done, mem_req, mem_we, mem_ack, power_down;
    logic [23:0] program_counter, fetch_addr, effective_addr, mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    logic [4:0] n;
    int mismatches = 0, n_compared = 0, cyc = 0;
    cma_alu_t r_alu [0:6] = '{cma_alu_addsub, cma_alu_mulu_b, cma_alu_mulu_w,
        cma_alu_muls_b, cma_alu_muls_w, cma_alu_div_b, cma_alu_div_w};
    logic [4:0] r_st [0:6] = '{CMA_ST_ADDSUB, CMA_ST_MULU_B, CMA_ST_MULU_W,
        CMA_ST_MULS_B, CMA_ST_MULS_W, CMA_ST_DIV_B, CMA_ST_DIV_W};
    cma_core dut (.clk, .rst_b, .mode_pin, .mode_wide, .op_valid, .op_kind, .op_arg,
        .op_ready, .op_done, .sp_in, .ccr_in, .exr_in, .exr_valid, .sp_out,
        .program_counter, .pc_advance, .fetch_addr, .idx_go, .idx_post, .idx_step,
        .idx_reg_in, .idx_reg_out, .effective_addr, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack, .wake, .power_down);
    cma_mem_model mem (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
        .mem_ack, .lat);
    initial
        forever #2.5 clk = ~clk;
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // whole run is under two hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic go(cma_op_t k, logic [7:0] a);
        @(posedge clk);
        op_valid <= 1'b1;
        op_kind <= k;
        op_arg <= a;
        @(posedge clk);
        op_valid <= 1'b0;
    endtask
    // n counts edges from take until op_done is seen
    task automatic run(cma_op_t k, logic [7:0] a);
        go(k, a);
        n = 5'h0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (op_done !== 1'b1 && n < 5'h1f);
    endtask
    task automatic reset_dut();
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("mode", 1'b1, mode_wide)
        `CHK("pc", 24'h0, program_counter)
        `CHK("down", 1'b0, power_down)
        `CHK("ready", 1'b1, op_ready)
    endtask
    task automatic idx(logic p, logic [2:0] s, logic [31:0] r, logic [31:0] e, logic [23:0] a);
        @(posedge clk);
        idx_go <= 1'b1;
        idx_post <= p;
        idx_step <= s;
        idx_reg_in <= r;
        @(posedge clk);
        idx_go <= 1'b0;
        #1;
        `CHK("idx", e, idx_reg_out)
        `CHK("ea", a, effective_addr)
    endtask
    initial
    begin
        reset_dut();
        for (int i = 0; i < 7; i++)
        begin
            run(cma_op_exec, {5'h0, r_alu[i]});
            `CHK("states", r_st[i], n)
        end
        $display("test exec done");
        mem.m[8] = 16'h12ab;
        mem.m[9] = 16'h3456;
        mem.m[16] = 16'h0000;
        mem.m[17] = 16'h0201;
        @(posedge clk);
        lat <= 2'h2;
        run(cma_op_jump, 8'h10);
        `CHK("jump", 24'hab3456, program_counter)
        @(posedge clk);
        pc_advance <= 1'b1;
        @(posedge clk);
        pc_advance <= 1'b0;
        sp_in <= 32'h100;
        run(cma_op_call, 8'h20);
        `CHK("ret lo", 16'h3458, mem.m[8'h7f])
        `CHK("ret hi", 16'h00ab, mem.m[8'h7e])
        `CHK("sp", 32'hfc, sp_out)
        `CHK("fetch", 24'h000200, fetch_addr)
        $display("test branch done");
        mem.m[6] = 16'hff01;
        mem.m[7] = 16'h1234;
        mem.m[8'h2d] = 16'hdead;
        @(posedge clk);
        lat <= 2'h0;
        sp_in <= 32'h80;
        ccr_in <= 8'h85;
        exr_in <= 8'h07;
        exr_valid <= 1'b1;
        run(cma_op_exception, 8'h03);
        `CHK("pc lo", 16'h0201, mem.m[8'h3f])
        `CHK("ccr", 16'h8500, mem.m[8'h3e])
        `CHK("exr", 16'h0700, mem.m[8'h3d])
        `CHK("sp", 32'h7a, sp_out)
        `CHK("vector", 24'h011234, program_counter)
        @(posedge clk);
        sp_in <= 32'h60;
        exr_valid <= 1'b0;
        run(cma_op_exception, 8'h03);
        `CHK("no exr", 16'hdead, mem.m[8'h2d])
        `CHK("ccr", 16'h8501, mem.m[8'h2e])
        `CHK("sp", 32'h5c, sp_out)
        $display("test exception done");
        idx(1'b1, 3'h4, 32'h0001fffe, 32'h00020002, 24'h01fffe);
        idx(1'b0, 3'h2, 32'h00010000, 32'h0000fffe, 24'h00fffe);
        $display("test index done");
        go(cma_op_sleep, 8'h0);
        repeat (4) @(posedge clk);
        #1;
        `CHK("down", 1'b1, power_down)
        `CHK("busy", 1'b0, op_ready)
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK("awake", 1'b0, power_down)
        $display("test sleep done");
        @(posedge clk);
        mode_pin <= 1'b0;
        reset_dut();
        `CHK("sp rst", 32'h0, sp_out)
        $display("test reset done");
        final_report();
    end
endmodule
